// [rtl/fmf_field_memory.sv]
// dual port field memory organised as a fifo with block access
//
// Behaviour
// R1: stores 245772 words of 12 bits, reached by sequential pointers.
// R2: block mode starts access at any of 6144 blocks of 40 words.
// R3: block mode is entered only right after a pointer reset.
// R4: separate 12-bit write and read ports.
// R5: write and read ports have own clocks and controls, run asynchronously.
// R6: controller resets write pointer to zero or a block start first.
// R7: controller resets read pointer to zero or a block start first.
// R8: reading never alters stored words; data rereads after each read reset.
// R9: contents and pointers survive clock pauses of any length.
// R10: first write clock edge after reset strobe rises loads lowest address.
// R11: write pointer advances on each write clock edge with enable high.
// R12: input mask low at previous edge discards the word.
// R13: pointers wrap from address 245759 back to zero.
// R14: read side mirrors write side with its own reset and enable; read pointer holds in block entry latency, write pointer does not.
// R15: data outputs driven only while output enable is high; READ_DATA_OUT_O is always driven, only READ_DATA_OE_O follows it.
`timescale 1ns/1ns
module fmf_field_memory
  import fmf_pkg::*;
#(
  parameter int DEPTH = TOTAL_WORDS
)(
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic WRITE_PORT_CLOCK_I,
  input wire logic WRITE_POINTER_RESET_I,
  input wire logic WRITE_ADVANCE_EN_I,
  input wire logic INPUT_MASK_ENABLE_I,
  input wire logic [WORD_W-1:0] WRITE_DATA_IN_I,
  input wire logic READ_PORT_CLOCK_I,
  input wire logic READ_POINTER_RESET_I,
  input wire logic READ_ADVANCE_ENABLE_I,
  input wire logic OUTPUT_ENABLE_I,
  output logic [WORD_W-1:0] READ_DATA_OUT_O,
  output logic READ_DATA_OE_O
);
  // storage is plain flops/ram here; no refresh needed and idle clocks lose nothing [R9]
  logic [WORD_W-1:0] mem [DEPTH]; // [R1]

  fmf_seq_if wseq ();
  fmf_seq_if rseq ();

  // write port
  logic wclk_q;
  logic wrst_q;
  logic wrst_arm;
  logic [PTR_W-1:0] wptr;
  logic pend_valid;
  logic pend_keep;
  logic [PTR_W-1:0] pend_addr;

  // port clocks are sampled levels of the system clock domain [R5]
  wire w_edge = WRITE_PORT_CLOCK_I && !wclk_q;
  wire wrst_rise = WRITE_POINTER_RESET_I && !wrst_q;
  wire w_reset = w_edge && (wrst_arm || wrst_rise);
  wire w_adv = w_edge && !w_reset && WRITE_ADVANCE_EN_I;
  wire w_commit = w_edge && pend_valid && pend_keep;
  wire [PTR_W-1:0] wptr_inc = (wptr == PTR_LAST) ? PTR_ZERO_ADDR : wptr + PTR_ONE; // [R13]
  wire [PTR_W-1:0] wblk_ptr = PTR_W'(PTR_ZERO_ADDR + PTR_W'(wseq.blk_addr) * BLK_STRIDE);

  assign wseq.edge_seen = w_edge;
  assign wseq.rst_edge = w_reset;
  assign wseq.ctl_en = WRITE_ADVANCE_EN_I;
  assign wseq.ctl_mask = INPUT_MASK_ENABLE_I;
  assign wseq.data_bit = WRITE_DATA_IN_I[0];

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      wclk_q <= 1'b0;
      wrst_q <= 1'b0;
      wrst_arm <= 1'b0;
    end else begin
      wclk_q <= WRITE_PORT_CLOCK_I;
      wrst_q <= WRITE_POINTER_RESET_I;
      if (w_edge) begin
        wrst_arm <= 1'b0;
      end else if (wrst_rise) begin
        wrst_arm <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      wptr <= PTR_RESET;
    end else if (w_reset) begin
      wptr <= PTR_RESET; // [R10]
    end else if (wseq.load) begin
      wptr <= wblk_ptr; // [R2]
    end else if (w_adv) begin
      wptr <= wptr_inc; // [R11]
    end
  end

  // address and mask are taken at the enable edge, the word at the next edge
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      pend_valid <= 1'b0;
      pend_keep <= 1'b0;
      pend_addr <= PTR_RESET;
    end else if (w_edge) begin
      pend_valid <= w_adv && !wseq.busy;
      pend_keep <= INPUT_MASK_ENABLE_I; // [R12]
      pend_addr <= wptr;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (w_commit) begin
      mem[pend_addr] <= WRITE_DATA_IN_I; // [R4] [R12]
    end
  end

  // read port
  logic rclk_q;
  logic rrst_q;
  logic rrst_arm;
  logic [PTR_W-1:0] rptr;
  logic [WORD_W-1:0] rdata;

  wire r_edge = READ_PORT_CLOCK_I && !rclk_q;
  wire rrst_rise = READ_POINTER_RESET_I && !rrst_q;
  wire r_reset = r_edge && (rrst_arm || rrst_rise);
  wire r_adv = r_edge && !r_reset && READ_ADVANCE_ENABLE_I && !rseq.busy;
  wire [PTR_W-1:0] rptr_inc = (rptr == PTR_LAST) ? PTR_ZERO_ADDR : rptr + PTR_ONE; // [R13]
  wire [PTR_W-1:0] rblk_ptr = PTR_W'(PTR_ZERO_ADDR + PTR_W'(rseq.blk_addr) * BLK_STRIDE);

  // read side has no mask pin; output enable takes that role in the entry sequence
  assign rseq.edge_seen = r_edge;
  assign rseq.rst_edge = r_reset;
  assign rseq.ctl_en = READ_ADVANCE_ENABLE_I;
  assign rseq.ctl_mask = OUTPUT_ENABLE_I;
  assign rseq.data_bit = OUTPUT_ENABLE_I;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rclk_q <= 1'b0;
      rrst_q <= 1'b0;
      rrst_arm <= 1'b0;
    end else begin
      rclk_q <= READ_PORT_CLOCK_I;
      rrst_q <= READ_POINTER_RESET_I;
      if (r_edge) begin
        rrst_arm <= 1'b0;
      end else if (rrst_rise) begin
        rrst_arm <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rptr <= PTR_RESET;
    end else if (r_reset) begin
      rptr <= PTR_RESET; // [R14]
    end else if (rseq.load) begin
      rptr <= rblk_ptr; // [R2]
    end else if (r_adv) begin
      rptr <= rptr_inc; // [R14]
    end
  end

  // read only samples the array, nothing is consumed [R8]
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rdata <= '0;
    end else if (r_adv) begin
      rdata <= mem[rptr]; // [R14]
    end
  end

  assign READ_DATA_OUT_O = rdata;
  assign READ_DATA_OE_O = OUTPUT_ENABLE_I; // [R15]

  fmf_blk_entry u_wr_entry (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .sq(wseq.seq)
  );

  fmf_blk_entry u_rd_entry (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .sq(rseq.seq)
  );
endmodule

// [rtl/fmf_pkg.sv]
// shared constants for the field memory fifo
package fmf_pkg;
  localparam int WORD_W = 12;
  localparam int CACHE_WORDS = 12;
  localparam int ARRAY_WORDS = 245760;
  localparam int TOTAL_WORDS = CACHE_WORDS + ARRAY_WORDS;
  localparam int PTR_W = 18;
  localparam int BLK_W = 13;
  localparam int BLK_COUNT = 6144;
  localparam int BLK_WORDS = 40;
  localparam int PRE_EDGES = 4;
  localparam int LAT_EDGES = 18;
  localparam int CNT_W = 5;
  localparam logic [PTR_W-1:0] PTR_RESET = 18'h00000;
  localparam logic [PTR_W-1:0] PTR_ZERO_ADDR = 18'h0000c;
  localparam logic [PTR_W-1:0] PTR_LAST = 18'h3c00b;
  localparam logic [PTR_W-1:0] PTR_ONE = 18'h00001;
  localparam logic [PTR_W-1:0] BLK_STRIDE = 18'h00028;
  localparam logic [BLK_W-1:0] BLK_LIMIT = 13'h1800;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_PRE_LAST = 5'h04;
  localparam logic [CNT_W-1:0] CNT_ADDR_LAST = 5'h0d;
  localparam logic [CNT_W-1:0] CNT_LAT_LAST = 5'h12;
  localparam logic [CNT_W-1:0] CNT_CLEAR = 5'h00;
  localparam logic [CNT_W-1:0] CNT_PAIR_END = 5'h02;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PRE, SEQ_ADDR, SEQ_LAT} fmf_seq_state_e;
endpackage

// [rtl/fmf_seq_if.sv]
// port logic to block entry sequencer signals
`timescale 1ns/1ns
interface fmf_seq_if;
  import fmf_pkg::*;
  logic edge_seen;
  logic rst_edge;
  logic ctl_en;
  logic ctl_mask;
  logic data_bit;
  logic load;
  logic busy;
  logic [BLK_W-1:0] blk_addr;
  modport port (output edge_seen, rst_edge, ctl_en, ctl_mask, data_bit,
    input load, busy, blk_addr);
  modport seq (input edge_seen, rst_edge, ctl_en, ctl_mask, data_bit,
    output load, busy, blk_addr);
endinterface

// [rtl/fmf_blk_entry.sv]
// random block access entry sequencer for one port
`timescale 1ns/1ns
module fmf_blk_entry
  import fmf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  fmf_seq_if.seq sq
);
  fmf_seq_state_e state;
  logic [CNT_W-1:0] cnt;
  logic [BLK_W-1:0] shreg;
  logic use_mask_pin;
  logic load_q;
  wire pair_early = (cnt < CNT_PAIR_END);
  wire pre_ok = pair_early ? (!sq.ctl_mask && sq.ctl_en) : (sq.ctl_mask && !sq.ctl_en);
  wire first_bit = (cnt == CNT_CLEAR);
  wire sel_now = first_bit ? sq.ctl_en : use_mask_pin;
  wire addr_bit = sel_now ? sq.ctl_mask : sq.data_bit;
  wire [BLK_W-1:0] next_shreg = {shreg[BLK_W-2:0], addr_bit};
  wire blk_valid = (shreg < BLK_LIMIT);

  assign sq.load = load_q;
  assign sq.busy = (state == SEQ_LAT);
  assign sq.blk_addr = shreg;

  // only entered from a pointer reset; any further reset aborts the mode [R3]
  always_ff @(posedge clk_i) begin
    load_q <= 1'b0;
    if (!rst_n_i) begin
      state <= SEQ_IDLE;
      cnt <= CNT_CLEAR;
      shreg <= '0;
      use_mask_pin <= 1'b0;
    end else if (sq.rst_edge) begin
      state <= SEQ_PRE; // [R3]
      cnt <= CNT_CLEAR;
    end else if (sq.edge_seen) begin
      case (state)
        SEQ_PRE: begin
          if (!pre_ok) begin
            state <= SEQ_IDLE;
          end else if (cnt == CNT_PRE_LAST - CNT_ONE) begin
            state <= SEQ_ADDR;
            cnt <= CNT_CLEAR;
          end else begin
            cnt <= cnt + CNT_ONE;
          end
        end
        SEQ_ADDR: begin
          if (first_bit) begin
            use_mask_pin <= sq.ctl_en;
          end
          shreg <= next_shreg;
          if (cnt == CNT_ADDR_LAST - CNT_ONE) begin
            state <= SEQ_LAT;
            cnt <= CNT_CLEAR;
          end else begin
            cnt <= cnt + CNT_ONE;
          end
        end
        SEQ_LAT: begin
          // out of range addresses are dropped rather than locking up
          if (cnt == CNT_LAT_LAST - CNT_ONE) begin
            state <= SEQ_IDLE;
            load_q <= blk_valid; // [R2]
          end else begin
            cnt <= cnt + CNT_ONE;
          end
        end
        default: state <= SEQ_IDLE;
      endcase
    end
  end
endmodule

// [bench/fmf_chk_sva.sv]
// read side assertion checker for the field memory
`timescale 1ns/1ns
module fmf_chk_sva
  import fmf_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic READ_PORT_CLOCK_I,
  input wire logic READ_ADVANCE_ENABLE_I,
  input wire logic OUTPUT_ENABLE_I,
  input wire logic [WORD_W-1:0] READ_DATA_OUT_O,
  input wire logic READ_DATA_OE_O
);
  logic rclk_q;
  logic rd_edge;
  always_ff @(posedge CLK_SYS_I) begin
    rclk_q <= READ_PORT_CLOCK_I;
  end
  assign rd_edge = READ_PORT_CLOCK_I & ~rclk_q;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  AST_OE_COPY: assert property (READ_DATA_OE_O == OUTPUT_ENABLE_I)
    else $error("oe copy");
  AST_OE_RISE: assert property ($rose(OUTPUT_ENABLE_I) |-> READ_DATA_OE_O)
    else $error("oe rise");
  AST_OE_LOW: assert property (!OUTPUT_ENABLE_I |-> !READ_DATA_OE_O)
    else $error("oe low");
  AST_OUT_CAUSE: assert property ($changed(READ_DATA_OUT_O) |-> $past(rd_edge && READ_ADVANCE_ENABLE_I))
    else $error("out cause");
  AST_EN_LOW_HOLD: assert property ($past(rd_edge) && !$past(READ_ADVANCE_ENABLE_I) |-> $stable(READ_DATA_OUT_O))
    else $error("en low hold");
  AST_ONE_STEP: assert property (rd_edge && READ_ADVANCE_ENABLE_I |=> ##1 $stable(READ_DATA_OUT_O))
    else $error("one step");
  // a stalled read clock must never lose the presented word
  AST_PAUSE_HOLD: assert property ($stable(READ_PORT_CLOCK_I) [*3] |-> $stable(READ_DATA_OUT_O))
    else $error("pause hold");
  AST_LOW_HOLD: assert property (!READ_PORT_CLOCK_I [*2] |-> $stable(READ_DATA_OUT_O))
    else $error("low hold");
endmodule
bind fmf_field_memory fmf_chk_sva chk (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
  .READ_PORT_CLOCK_I(READ_PORT_CLOCK_I), .READ_ADVANCE_ENABLE_I(READ_ADVANCE_ENABLE_I),
  .OUTPUT_ENABLE_I(OUTPUT_ENABLE_I), .READ_DATA_OUT_O(READ_DATA_OUT_O),
  .READ_DATA_OE_O(READ_DATA_OE_O));

// [bench/fmf_ctl_model.sv]
// controller model driving the write and read ports
`timescale 1ns/1ns
module fmf_ctl_model
  import fmf_pkg::*;
(
  input wire logic clk_i,
  output logic wclk_o,
  output logic wrst_o,
  output logic wen_o,
  output logic wmask_o,
  output logic [WORD_W-1:0] wdata_o,
  output logic rclk_o,
  output logic rrst_o,
  output logic ren_o,
  output logic oe_o
);
  initial begin
    {wclk_o, wrst_o, wen_o, wmask_o, rclk_o, rrst_o, ren_o, oe_o} = 8'h00;
    wdata_o = 12'h000;
  end
  // clock low one cycle then high: the design only sees sampled levels
  task automatic wedge(input logic r, input logic e, input logic m, input logic [WORD_W-1:0] d);
    @(posedge clk_i);
    wclk_o <= 1'b0;
    wrst_o <= r;
    wen_o <= e;
    wmask_o <= m;
    wdata_o <= d;
    @(posedge clk_i);
    wclk_o <= 1'b1;
  endtask
  task automatic redge(input logic r, input logic e, input logic o);
    @(posedge clk_i);
    rclk_o <= 1'b0;
    rrst_o <= r;
    ren_o <= e;
    oe_o <= o;
    @(posedge clk_i);
    rclk_o <= 1'b1;
  endtask
endmodule

// [bench/tb_top.sv]
// self-checking bench for the field memory
`timescale 1ns/1ns
module tb_top;
  import fmf_pkg::*;
  logic clk, rst_n, wclk, wrst, wen, wmask, rclk, rrst, ren, oe, rd_oe;
  logic [WORD_W-1:0] wdata;
  logic [WORD_W-1:0] rdata;
  int bad_count;
  int num_checks;
  logic [WORD_W-1:0] pa [4] = '{12'h5a3, 12'hfff, 12'h0c1, 12'h800};
  logic [WORD_W-1:0] pb [4] = '{12'h3c7, 12'h000, 12'h9e2, 12'h17f};
  fmf_field_memory uut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .WRITE_PORT_CLOCK_I(wclk),
    .WRITE_POINTER_RESET_I(wrst), .WRITE_ADVANCE_EN_I(wen), .INPUT_MASK_ENABLE_I(wmask),
    .WRITE_DATA_IN_I(wdata), .READ_PORT_CLOCK_I(rclk), .READ_POINTER_RESET_I(rrst),
    .READ_ADVANCE_ENABLE_I(ren), .OUTPUT_ENABLE_I(oe), .READ_DATA_OUT_O(rdata),
    .READ_DATA_OE_O(rd_oe));
  fmf_ctl_model ctl (.clk_i(clk), .wclk_o(wclk), .wrst_o(wrst), .wen_o(wen),
    .wmask_o(wmask), .wdata_o(wdata), .rclk_o(rclk), .rrst_o(rrst), .ren_o(ren), .oe_o(oe));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // data for a word goes out at the edge after its enable edge
  task automatic wr_words(input logic [WORD_W-1:0] d [4], input logic [3:0] m);
    ctl.wedge(1'b1, 1'b1, 1'b0, 12'h000);
    for (int i = 0; i <= 4; i++) begin
      ctl.wedge(1'b0, i < 4, (i < 4) && m[i[1:0]], (i > 0) ? d[i-1] : 12'h000);
    end
  endtask
  task automatic rd_one(input logic e, input logic [WORD_W-1:0] exp);
    ctl.redge(1'b0, e, 1'b1);
    repeat (2) @(posedge clk);
    #1 chk(rdata, exp);
  endtask
  task automatic rd_words(input logic [WORD_W-1:0] exp [4]);
    ctl.redge(1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rd_one(1'b1, exp[i]);
    end
  endtask
  task automatic blk_wr(input logic [BLK_W-1:0] b, input logic [WORD_W-1:0] d);
    ctl.wedge(1'b1, 1'b0, 1'b0, 12'h000);
    for (int i = 1; i <= 35; i++) begin
      ctl.wedge(1'b0, i <= 2, (i == 3) || (i == 4),
        (i >= 5 && i <= 17) ? {11'h000, b[17-i]} : 12'h000);
    end
    ctl.wedge(1'b0, 1'b1, 1'b1, 12'h000);
    ctl.wedge(1'b0, 1'b0, 1'b0, d);
  endtask
  // last block on both sides, then one word past the array end lands on address zero
  task automatic wrap_rw(input logic [BLK_W-1:0] b, input logic [WORD_W-1:0] d0,
      input logic [WORD_W-1:0] d1);
    blk_wr(b, d0);
    repeat (39) ctl.wedge(1'b0, 1'b1, 1'b0, 12'h000);
    ctl.wedge(1'b0, 1'b1, 1'b1, 12'h000);
    ctl.wedge(1'b0, 1'b0, 1'b0, d1);
    ctl.redge(1'b1, 1'b0, 1'b0);
    for (int i = 1; i <= 35; i++) begin
      ctl.redge(1'b0, i <= 2,
        (i == 3 || i == 4) ? 1'b1 : (i >= 5 && i <= 17) ? b[17-i] : 1'b0);
    end
    rd_one(1'b1, d0);
    repeat (39) ctl.redge(1'b0, 1'b1, 1'b1);
    rd_one(1'b1, d1);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    bad_count = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wr_words(pa, 4'hf);
    rd_words(pa);
    repeat (300) @(posedge clk);
    rd_words(pa);
    rd_one(1'b0, pa[3]);
    wr_words(pb, 4'hb);
    rd_words('{pb[0], pb[1], pa[2], pb[3]});
    ctl.redge(1'b0, 1'b0, 1'b0);
    #1 chk({11'h000, rd_oe}, 12'h000);
    ctl.redge(1'b0, 1'b0, 1'b1);
    #1 chk({11'h000, rd_oe}, 12'h001);
    blk_wr(13'h0001, 12'ha5c);
    ctl.redge(1'b1, 1'b0, 1'b1);
    repeat (52) ctl.redge(1'b0, 1'b1, 1'b1);
    rd_one(1'b1, 12'ha5c);
    wrap_rw(13'h17ff, 12'h6b4, 12'h2d9);
    end_sim();
  end
endmodule
